// ===== rtl/ep0_ctrl_consts.vh
// constants for the endpoint-0 stall, resume and clear-feature block
//
// Operation
// - stall bit forces STALL on endpoint 0
// - hardware sets stall on bad wValue
// - auto-request overrun sets stall, not halt
// - next SETUP clears stall, no STALL reply
// - late stall may give NAK first
// - software stall set only during firmware request
// - resume bit drives resume signalling
// - resume sampled on system clock only
// - flags set after status stage completes
// - read returns flags then clears all
// - disabled endpoint flags invalid, not set
// - bits 6..1 endpoints 7,4,3,2,1,0; bit7 zero
// - bit 0 flags clear-feature device request
`ifndef EP0_CTRL_CONSTS_VH
`define EP0_CTRL_CONSTS_VH

// register indices; byte address is four times the index
`define HS_CTRL_IDX 20'hf0544
`define CLR_STAT_IDX 20'hf0545
`define IRQ_STAT_IDX 20'hf0580
`define IRQ_MASK_IDX 20'hf0581

// handshake_pin_control fields
`define HS_RESUME_BIT 0
`define HS_STALL_BIT 3
`define HS_CTRL_RESET 8'h00

// clear_feature_status layout
`define CLR_DEV_BIT 0
`define CLR_EP_LSB 1
`define CLR_EP_MSB 6
`define CLR_STAT_RESET 8'h00
`define CLR_FLAGS_W 7

// interrupt status and mask layout
`define IRQ_W 3
`define IRQ_CLR_BIT 0
`define IRQ_HWSTALL_BIT 1
`define IRQ_SETUP_BIT 2
`define IRQ_RESET 3'h0

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== rtl/sticky_flags.v
// bank of sticky flags where a set beats a simultaneous clear
`timescale 1ns/1ps
module sticky_flags #(
  parameter W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] set,
  input wire clear_all,
  output wire [W-1:0] flags
);

  reg [W-1:0] flags_reg;
  reg [W-1:0] flags_next;

  // a set arriving with the clear survives to the next read
  always @* begin
    flags_next = clear_all ? {W{1'b0}} : flags_reg;
    flags_next = flags_next | set;
  end

  // synchronous active-low reset to all zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= {W{1'b0}};
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

// ===== rtl/ep0_stall_resume_ctrl.v
// endpoint-0 stall, resume and clear-feature status with axi4-lite slave
`timescale 1ns/1ps
`include "ep0_ctrl_consts.vh"
module ep0_stall_resume_ctrl (
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [31:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output wire awready,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  // axi4-lite write response
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // axi4-lite read address
  input wire [31:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output wire arready,
  // axi4-lite read data
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // usb engine side
  input wire setup_token,
  input wire ep0_token,
  input wire fw_request_active,
  input wire bad_config_value,
  input wire auto_overrun,
  input wire status_stage_done,
  input wire [6:0] clear_feature_sel,
  input wire [5:0] endpoint_enable,
  output wire ep0_stall_handshake,
  output wire ep0_force_stall,
  output wire resume_signal_drive,
  output wire irq
);

  //////////////////////////////////////////////////////////////////////////
  // write channel holding registers

  reg aw_full_reg;
  reg [31:0] aw_addr_reg;
  reg w_full_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;

  wire aw_take;
  wire w_take;
  wire do_write;
  wire b_done;
  wire [19:0] wr_idx;
  wire wr_aligned;
  wire wr_hit_hs;
  wire wr_hit_clr;
  wire wr_hit_stat;
  wire wr_hit_mask;
  wire wr_mapped;
  wire wr_lane0;

  // address and data are taken in either order, one write at a time
  assign awready = ~aw_full_reg;
  assign wready = ~w_full_reg;
  assign aw_take = awvalid & ~aw_full_reg;
  assign w_take = wvalid & ~w_full_reg;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign b_done = bvalid_reg & bready;

  // address decode on the held write address
  assign wr_idx = aw_addr_reg[21:2];
  assign wr_aligned = (aw_addr_reg[1:0] == 2'h0) &
                      (aw_addr_reg[31:22] == 10'h000);
  assign wr_hit_hs = wr_aligned & (wr_idx == `HS_CTRL_IDX);
  assign wr_hit_clr = wr_aligned & (wr_idx == `CLR_STAT_IDX);
  assign wr_hit_stat = wr_aligned & (wr_idx == `IRQ_STAT_IDX);
  assign wr_hit_mask = wr_aligned & (wr_idx == `IRQ_MASK_IDX);
  assign wr_mapped = wr_hit_hs | wr_hit_clr | wr_hit_stat | wr_hit_mask;

  // all registers are eight bits wide and live in byte lane 0
  assign wr_lane0 = w_strb_reg[0];

  // capture address and data, release both when the response is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (b_done) begin
        aw_full_reg <= 1'b0;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end else if (b_done) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // response follows both halves; unmapped address answers slverr
  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (b_done) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  //////////////////////////////////////////////////////////////////////////
  // read channel

  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  wire ar_take;
  wire [19:0] rd_idx;
  wire rd_aligned;
  wire rd_hit_hs;
  wire rd_hit_clr;
  wire rd_hit_stat;
  wire rd_hit_mask;
  reg [7:0] rd_byte;
  reg rd_mapped;

  // one read at a time: the next address waits for the data to go
  assign arready = ~rvalid_reg;
  assign ar_take = arvalid & ~rvalid_reg;

  // decode straight from the bus address during the accepting cycle
  assign rd_idx = araddr[21:2];
  assign rd_aligned = (araddr[1:0] == 2'h0) &
                      (araddr[31:22] == 10'h000);
  assign rd_hit_hs = rd_aligned & (rd_idx == `HS_CTRL_IDX);
  assign rd_hit_clr = rd_aligned & (rd_idx == `CLR_STAT_IDX);
  assign rd_hit_stat = rd_aligned & (rd_idx == `IRQ_STAT_IDX);
  assign rd_hit_mask = rd_aligned & (rd_idx == `IRQ_MASK_IDX);

  //////////////////////////////////////////////////////////////////////////
  // handshake_pin_control: stall and resume bits

  reg stall_reg;
  reg stall_next;
  reg resume_reg;
  reg resume_next;
  wire hs_write;
  wire hw_stall_set;
  wire [7:0] hs_reset_val;

  // a byte write that lands on lane 0 of the control register
  assign hs_write = do_write & wr_hit_hs & wr_lane0;

  // reset image of the control register, picked apart bit by bit
  assign hs_reset_val = `HS_CTRL_RESET;

  // hardware stall sources
  // the halt status bit lives elsewhere and is deliberately not touched
  assign hw_stall_set = bad_config_value | auto_overrun;

  // stall priority: setup clears, hardware sets, then software write
  always @* begin
    stall_next = stall_reg;
    if (hs_write) begin
      // firmware stall gated
      // a one only sticks while a firmware-handled request runs
      if (w_data_reg[`HS_STALL_BIT]) begin
        stall_next = fw_request_active ? 1'b1 : stall_reg;
      end else begin
        stall_next = 1'b0;
      end
    end
    if (hw_stall_set) begin
      stall_next = 1'b1;
    end
    if (setup_token) begin
      stall_next = 1'b0;
    end
  end

  // nothing here times the resume out; firmware must clear it
  always @* begin
    resume_next = resume_reg;
    if (hs_write) begin
      resume_next = w_data_reg[`HS_RESUME_BIT];
    end
  end

  // resume sampled on aclk
  // with aclk stopped the resume output simply freezes
  always @(posedge aclk) begin
    if (!aresetn) begin
      stall_reg <= hs_reset_val[`HS_STALL_BIT];
      resume_reg <= hs_reset_val[`HS_RESUME_BIT];
    end else begin
      stall_reg <= stall_next;
      resume_reg <= resume_next;
    end
  end

  // registered bit: a set in the token's own cycle misses it (nak)
  // and the stall lands on the following transfer
  assign ep0_stall_handshake = stall_reg & ~setup_token;
  assign ep0_force_stall = stall_reg;
  assign resume_signal_drive = resume_reg;

  //////////////////////////////////////////////////////////////////////////
  // clear_feature_status flags

  wire [6:0] clr_flags;
  wire [6:0] clr_valid;
  wire [6:0] clr_set;
  wire clr_read;

  // disabled endpoints not flagged
  // device flag has no endpoint, so it is always allowed
  assign clr_valid = {endpoint_enable, 1'b1};

  assign clr_set = status_stage_done ?
                   (clear_feature_sel & clr_valid) : 7'h00;

  // clearing read
  // the flags are cleared on the cycle the read address is taken
  assign clr_read = ar_take & rd_hit_clr;

  sticky_flags #(
    .W(`CLR_FLAGS_W)
  ) u_clr_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(clr_set),
    .clear_all(clr_read),
    .flags(clr_flags)
  );

  //////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  wire [2:0] irq_flags;
  wire [2:0] irq_set;
  wire irq_read;
  reg [2:0] irq_mask_reg;

  // events: clear-feature flag set, hardware stall, setup token
  assign irq_set = {setup_token, hw_stall_set, |clr_set};

  // reading the status register clears it; a new event still wins
  assign irq_read = ar_take & rd_hit_stat;

  sticky_flags #(
    .W(`IRQ_W)
  ) u_irq_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(irq_set),
    .clear_all(irq_read),
    .flags(irq_flags)
  );

  // mask register: a one lets the matching status bit through
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= `IRQ_RESET;
    end else if (do_write & wr_hit_mask & wr_lane0) begin
      irq_mask_reg <= w_data_reg[2:0];
    end
  end

  // level output, high while any unmasked status bit stands
  assign irq = |(irq_flags & irq_mask_reg);

  //////////////////////////////////////////////////////////////////////////
  // read data mux

  // fixed zero bits
  // clear-feature bit 7 is never stored and reads zero
  always @* begin
    rd_byte = 8'h00;
    rd_mapped = 1'b1;
    if (rd_hit_hs) begin
      rd_byte[`HS_STALL_BIT] = stall_reg;
      rd_byte[`HS_RESUME_BIT] = resume_reg;
    end else if (rd_hit_clr) begin
      rd_byte = {1'b0, clr_flags};
    end else if (rd_hit_stat) begin
      rd_byte = {5'h00, irq_flags};
    end else if (rd_hit_mask) begin
      rd_byte = {5'h00, irq_mask_reg};
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // data captured with the address, so a clearing read returns
  // the flags as they stood before the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_reg & rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

endmodule

// ===== tb/ep0_usb_host_model.sv
// usb host side model driving token and request events
`timescale 1ns/1ps
module ep0_usb_host_model (
  input wire aclk,
  output logic setup_token,
  output logic ep0_token,
  output logic fw_request_active,
  output logic bad_config_value,
  output logic auto_overrun,
  output logic status_stage_done,
  output logic [6:0] clear_feature_sel,
  output logic [5:0] endpoint_enable
);
  // quiet bus at time zero, every endpoint enabled
  initial begin
    {setup_token, ep0_token, fw_request_active} = 3'h0;
    {bad_config_value, auto_overrun, status_stage_done} = 3'h0;
    clear_feature_sel = 7'h00;
    endpoint_enable = 6'h3f;
  end
  task level(input logic fw, input logic [5:0] en);
    @(posedge aclk);
    fw_request_active <= fw;
    endpoint_enable <= en;
  endtask
  // one-cycle event
  // kind 0 setup, 1 bad wValue, 2 overrun, 3 status stage done;
  // the selector is inverted after release so stale values never help
  task pulse(input logic [1:0] k, input logic [6:0] sel);
    @(posedge aclk);
    setup_token <= k == 2'h0;
    ep0_token <= k == 2'h0;
    bad_config_value <= k == 2'h1;
    auto_overrun <= k == 2'h2;
    status_stage_done <= k == 2'h3;
    clear_feature_sel <= sel;
    @(posedge aclk);
    {setup_token, ep0_token, bad_config_value} <= 3'h0;
    {auto_overrun, status_stage_done} <= 2'h0;
    clear_feature_sel <= ~sel;
  endtask
endmodule

// ===== tb/ep0_ctrl_monitor.sv
// assertions on the ep0 stall, resume and status block ports
`timescale 1ns/1ps
module ep0_ctrl_monitor (
  input wire aclk,
  input wire aresetn,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire bvalid,
  input wire setup_token,
  input wire fw_request_active,
  input wire bad_config_value,
  input wire auto_overrun,
  input wire ep0_stall_handshake,
  input wire ep0_force_stall,
  input wire resume_signal_drive,
  input wire irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  a_stall_reply: assert property
    (ep0_stall_handshake == (ep0_force_stall && !setup_token))
    else $error("stall reply mismatch");
  a_setup_clear: assert property
    (setup_token |=> !ep0_force_stall)
    else $error("setup left stall set");
  a_bad_value_stall: assert property
    (bad_config_value && !setup_token |=> ep0_force_stall)
    else $error("bad value did not stall");
  a_overrun_stall: assert property
    (auto_overrun && !setup_token |=> ep0_force_stall)
    else $error("overrun did not stall");
  a_sw_stall_gate: assert property
    ($rose(ep0_force_stall) |-> $past(bad_config_value)
      || $past(auto_overrun) || $past(fw_request_active))
    else $error("stall set without cause");
  // a reset in mid-run may drop both bits without a bus cycle
  a_stall_fall: assert property
    ($fell(ep0_force_stall) |-> !$past(aresetn) || $past(setup_token)
      || $rose(bvalid))
    else $error("stall cleared without cause");
  a_resume_write: assert property
    ($changed(resume_signal_drive) |-> !$past(aresetn) || $rose(bvalid))
    else $error("resume changed without write");
  a_read_answer: assert property
    (arvalid && arready |=> rvalid && rdata[31:7] == 25'h0)
    else $error("read answer late or wide");
  cover property (setup_token && ep0_force_stall);
  cover property (bad_config_value);
  cover property (irq);
  cover property (rvalid && rresp == 2'h2);
endmodule

// ===== tb/usb_ep0_stall_resume_clear_status_tb.sv
// self-checking bench for the ep0 stall, resume and status block
`timescale 1ns/1ps
`include "ep0_ctrl_consts.vh"
module usb_ep0_stall_resume_clear_status_tb;
  localparam [31:0] HS = {10'h0, `HS_CTRL_IDX, 2'h0};
  localparam [31:0] CS = {10'h0, `CLR_STAT_IDX, 2'h0};
  localparam [31:0] IS = {10'h0, `IRQ_STAT_IDX, 2'h0};
  localparam [31:0] IM = {10'h0, `IRQ_MASK_IDX, 2'h0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, d;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire setup_token, ep0_token, fw_request_active, bad_config_value;
  wire auto_overrun, status_stage_done, ep0_stall_handshake;
  wire ep0_force_stall, resume_signal_drive;
  wire [6:0] clear_feature_sel;
  wire [5:0] endpoint_enable;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////
  // protection fixed and full strobes: the block uses the low byte
  ep0_stall_resume_ctrl uut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .setup_token, .ep0_token, .fw_request_active,
    .bad_config_value, .auto_overrun, .status_stage_done,
    .clear_feature_sel, .endpoint_enable, .ep0_stall_handshake,
    .ep0_force_stall, .resume_signal_drive, .irq
  );
  ep0_usb_host_model host (
    .aclk, .setup_token, .ep0_token, .fw_request_active,
    .bad_config_value, .auto_overrun, .status_stage_done,
    .clear_feature_sel, .endpoint_enable
  );
  // 4 ns clock
  always #2 aclk = ~aclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // each channel is released only at the edge that takes it
  task wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    {awvalid, wvalid, bready} <= 3'h7;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask
  task rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(HS, 32'h0);
    rdc(CS, 32'h0);
    $display("test reset values done");
    wr(HS, 8'h08);
    rdc(HS, 32'h0);
    host.level(1'b1, 6'h3f);
    wr(HS, 8'hfb);
    rdc(HS, 32'h09);
    chk(ep0_stall_handshake, 1'b1);
    chk(resume_signal_drive, 1'b1);
    host.pulse(2'h0, 7'h00);
    rdc(HS, 32'h01);
    wr(HS, 8'h00);
    chk(resume_signal_drive, 1'b0);
    host.level(1'b0, 6'h3f);
    $display("test firmware stall done");
    host.pulse(2'h1, 7'h00);
    rdc(HS, 32'h08);
    host.pulse(2'h0, 7'h00);
    rdc(HS, 32'h00);
    host.pulse(2'h2, 7'h00);
    rdc(HS, 32'h08);
    chk(ep0_stall_handshake, 1'b1);
    wr(HS, 8'h00);
    rdc(HS, 32'h00);
    $display("test hardware stall done");
    wr(IM, 8'h01);
    host.pulse(2'h3, 7'h7f);
    rdc(CS, 32'h7f);
    chk(irq, 1'b1);
    rdc(CS, 32'h00);
    rdc(IS, 32'h07);
    chk(irq, 1'b0);
    wr(CS, 8'hff);
    chk(r, `RESP_OKAY);
    rdc(CS, 32'h00);
    host.level(1'b0, 6'h20);
    host.pulse(2'h3, 7'h7f);
    rdc(CS, 32'h41);
    wr(IM, 8'h00);
    host.pulse(2'h3, 7'h01);
    rdc(CS, 32'h01);
    chk(irq, 1'b0);
    // status stage lands on the very edge that takes the clearing read
    fork
      rd(CS);
      host.pulse(2'h3, 7'h01);
    join
    chk(d, 32'h0);
    rdc(CS, 32'h01);
    $display("test clear feature done");
    rd(32'h0);
    chk(r, `RESP_SLVERR);
    chk(d, 32'h0);
    $display("test unmapped done");
    // a reset in mid-run must drop a standing resume request
    wr(HS, 8'h01);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(HS, 32'h0);
    chk(resume_signal_drive, 1'b0);
    $display("test mid-run reset done");
    stop_test;
  end
endmodule
bind ep0_stall_resume_ctrl ep0_ctrl_monitor mon (
  .aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .bvalid(bvalid),
  .setup_token(setup_token), .fw_request_active(fw_request_active),
  .bad_config_value(bad_config_value), .auto_overrun(auto_overrun),
  .ep0_stall_handshake(ep0_stall_handshake),
  .ep0_force_stall(ep0_force_stall),
  .resume_signal_drive(resume_signal_drive), .irq(irq)
);
